// [common/tmb_consts.svh]
// constants of the sixteen-bit timer: register indexes, bit positions, reset values
// assumes inclusion by the design and bench files, by bare name
`ifndef TMB_CONSTS_SVH
`define TMB_CONSTS_SVH
// ****************************************
// register indexes, byte address = 4 * index
// ****************************************
`define TMB_IDX_IRQ_CTRL 8'h0B
`define TMB_IDX_FLAG     8'h0C
`define TMB_IDX_CNT_LO   8'h0E
`define TMB_IDX_CNT_HI   8'h0F
`define TMB_IDX_TCTRL    8'h10
`define TMB_IDX_CMP_LO   8'h15
`define TMB_IDX_CMP_HI   8'h16
`define TMB_IDX_CCU_CTRL 8'h17
`define TMB_IDX_ENABLE   8'h8C
`define TMB_IDX_GATE     8'h8F
// ****************************************
// field positions
// ****************************************
`define TMB_BIT_TIMER_ON 0
`define TMB_BIT_SYNC     2
`define TMB_POS_CLKSRC   6
`define TMB_BIT_GATE_EN  7
`define TMB_BIT_OVF      0
`define TMB_BIT_CCU      2
`define TMB_BIT_OVF_IE   0
`define TMB_BIT_PERIPHERAL_IRQ_ENABLE     6
`define TMB_BIT_GIE      7
// ****************************************
// values
// ****************************************
`define TMB_RST_BYTE     8'h00
`define TMB_FLAG_MASK    8'h05
`define TMB_CNT_MAX      16'hFFFF
`define TMB_CNT_ZERO     16'h0000
`define TMB_CNT_ONE      16'h0001
`define TMB_ISR_VECTOR   16'h0004
`define TMB_INSTR_DIV    2'h3
`endif

// [common/tmb_pkg.sv]
// types of the sixteen-bit timer
// assumes tmb_consts.svh on the include path
package tmb_pkg;
  typedef enum logic [1:0] {
    TMB_SRC_INSTR = 2'h0,
    TMB_SRC_SYS   = 2'h1,
    TMB_SRC_PIN   = 2'h2,
    TMB_SRC_RSVD  = 2'h3
  } tmb_src_type;
  typedef enum logic [3:0] {
    TMB_CCU_OFF     = 4'h0,
    TMB_CCU_CAPTURE = 4'h4,
    TMB_CCU_COMPARE = 4'h8,
    TMB_CCU_SPECIAL = 4'hB
  } tmb_ccu_type;
  typedef enum logic [1:0] {
    TMB_ST_AWAKE  = 2'b00,
    TMB_ST_ASLEEP = 2'b01,
    TMB_ST_WAKE   = 2'b11
  } tmb_state_type;
endpackage

// [rtl/tmb_tick.sv]
// clock source selection of the timer: one-cycle tick per counting edge
// assumes the pin is synchronous to clk_in
`timescale 1ns/1ps
`include "tmb_consts.svh"
module tmb_tick (
  input  wire logic              clk_in,
  input  wire logic              resetn_in,
  input  wire tmb_pkg::tmb_src_type src_in,
  input  wire logic              pin_in,
  output logic                   tick_out
);
  import tmb_pkg::*;
  logic [1:0] div_r;
  logic [1:0] div_nxt;
  logic       pin_r;
  logic       pin_nxt;
  // ****************************************
  // divider and edge detect
  // ****************************************
  always_comb begin
    div_nxt = 2'(div_r + 2'h1);
    pin_nxt = pin_in;
    case (src_in)
      TMB_SRC_INSTR: tick_out = (div_r == `TMB_INSTR_DIV);
      TMB_SRC_SYS:   tick_out = 1'b1;
      TMB_SRC_PIN:   tick_out = pin_in & ~pin_r;
      default:       tick_out = 1'b0;
    endcase
  end
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      div_r <= 2'h0;
      pin_r <= 1'b0;
    end else begin
      div_r <= div_nxt;
      pin_r <= pin_nxt;
    end
  end
endmodule

// [rtl/tmb_timer.sv]
// sixteen-bit timer with capture/compare time base, classic wishbone slave
// assumes synchronous inputs, sleep level from the core, byte lane 0 carries data
//
// Chosen here: the Wishbone slave port.
`timescale 1ns/1ps
`include "tmb_consts.svh"
// Summary of operation
// - count climbs to maximum, then wraps zero
// - wrap sets the overflow flag
// - interrupt needs on, enable, peripheral, global
// - sleep counting only in asynchronous counter mode
// - overflow in sleep wakes the core if enable and peripheral are set
// - wake with global enable vectors to 0004h
// - count is the capture/compare time base
// - capture event copies count into compare pair
// - compare match raises an event
// - match may be a special event trigger
// - special trigger clears count, no overflow flag
// - count write beats special trigger clear
module tmb_timer #(
  parameter int AW = 10
) (
  input  wire logic          CLK_IN,
  input  wire logic          RESETN_IN,
  input  wire logic          CYC_IN,
  input  wire logic          STB_IN,
  input  wire logic          WE_IN,
  input  wire logic [AW-1:0] ADR_IN,
  input  wire logic [3:0]    SEL_IN,
  input  wire logic [31:0]   DAT_IN,
  output logic      [31:0]   DAT_OUT,
  output logic               ACK_OUT,
  input  wire logic          SLEEP_IN,
  input  wire logic          TIMER_PIN_IN,
  input  wire logic          GATE_PIN_IN,
  input  wire logic          CCU_PIN_IN,
  output logic      [15:0]   COUNT_OUT,
  output logic               COMPARE_EVENT_OUT,
  output logic               IRQ_OUT,
  output logic               WAKE_OUT,
  output logic               VECTOR_REQ_OUT,
  output logic      [15:0]   ISR_VECTOR_OUT
);
  import tmb_pkg::*;
  logic [15:0]   cnt_r, cnt_nxt;
  logic [15:0]   cmp_r, cmp_nxt;
  logic [7:0]    tctrl_r, tctrl_nxt;
  logic [7:0]    gate_r, gate_nxt;
  tmb_ccu_type   ccu_r, ccu_nxt;
  logic [7:0]    flag_r, flag_nxt;
  logic [7:0]    enable_r, enable_nxt;
  logic [7:0]    irqc_r, irqc_nxt;
  logic          ack_r, ack_nxt;
  logic [31:0]   dat_r, dat_nxt;
  tmb_state_type st_r, st_nxt;
  logic          match_r, match_nxt;
  logic          ccpin_r, ccpin_nxt;
  logic          cmpev_r, cmpev_nxt;
  logic          irq_r, irq_nxt;
  logic          vec_r, vec_nxt;
  logic          tick;
  logic          wr_any, rd_req;
  logic [7:0]    idx;
  logic          wr_lo, wr_hi, cnt_wr, flag_wr;
  logic          timer_on, async_mode, gate_ok, adv, ovf;
  logic          cap_mode, cmp_mode, spec, match_now, cmp_evt, cap_evt;
  logic          wake_ok, global_irq_enable;
  tmb_src_type   src;
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic wr_hit(input logic en, input logic [7:0] a,
                                  input logic [7:0] t);
    wr_hit = en && (a == t);
  endfunction
  function automatic logic [7:0] rd_byte(input logic [7:0] a);
    case (a)
      `TMB_IDX_IRQ_CTRL: rd_byte = irqc_r;
      `TMB_IDX_FLAG:     rd_byte = flag_r;
      `TMB_IDX_CNT_LO:   rd_byte = cnt_r[7:0];
      `TMB_IDX_CNT_HI:   rd_byte = cnt_r[15:8];
      `TMB_IDX_TCTRL:    rd_byte = tctrl_r;
      `TMB_IDX_CMP_LO:   rd_byte = cmp_r[7:0];
      `TMB_IDX_CMP_HI:   rd_byte = cmp_r[15:8];
      `TMB_IDX_CCU_CTRL: rd_byte = {4'h0, ccu_r};
      `TMB_IDX_ENABLE:   rd_byte = enable_r;
      `TMB_IDX_GATE:     rd_byte = gate_r;
      default:           rd_byte = `TMB_RST_BYTE;
    endcase
  endfunction
  // ****************************************
  // clock source
  // ****************************************
  tmb_tick u_tick (
    .clk_in    (CLK_IN),
    .resetn_in (RESETN_IN),
    .src_in    (src),
    .pin_in    (TIMER_PIN_IN),
    .tick_out  (tick)
  );
  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    src        = tmb_src_type'(tctrl_r[`TMB_POS_CLKSRC +: 2]);
    idx        = ADR_IN[9:2];
    wr_any     = CYC_IN & STB_IN & WE_IN & SEL_IN[0] & ack_r;
    rd_req     = CYC_IN & STB_IN & ~WE_IN & ~ack_r;
    wr_lo      = wr_hit(wr_any, idx, `TMB_IDX_CNT_LO);
    wr_hi      = wr_hit(wr_any, idx, `TMB_IDX_CNT_HI);
    cnt_wr     = wr_lo | wr_hi;
    flag_wr    = wr_hit(wr_any, idx, `TMB_IDX_FLAG);
    timer_on   = tctrl_r[`TMB_BIT_TIMER_ON];
    global_irq_enable        = irqc_r[`TMB_BIT_GIE];
    async_mode = tctrl_r[`TMB_BIT_SYNC] && (src == TMB_SRC_PIN);
    gate_ok    = ~gate_r[`TMB_BIT_GATE_EN] | GATE_PIN_IN;
    adv        = tick & timer_on & gate_ok & (~SLEEP_IN | async_mode);
    cap_mode   = (ccu_r == TMB_CCU_CAPTURE);
    cmp_mode   = (ccu_r == TMB_CCU_COMPARE) || (ccu_r == TMB_CCU_SPECIAL);
    spec       = (ccu_r == TMB_CCU_SPECIAL);
    match_now  = cmp_mode && (cnt_r == cmp_r);
    cmp_evt    = match_now & ~match_r;
    cap_evt    = cap_mode & CCU_PIN_IN & ~ccpin_r;
    ovf        = adv && (cnt_r == `TMB_CNT_MAX) && !cnt_wr && !(cmp_evt && spec);
    wake_ok    = timer_on & enable_r[`TMB_BIT_OVF_IE] & irqc_r[`TMB_BIT_PERIPHERAL_IRQ_ENABLE];
    // count: write first, then special clear, then increment
    cnt_nxt = cnt_r;
    if (cnt_wr) begin
      if (wr_lo) begin
        cnt_nxt[7:0] = DAT_IN[7:0];
      end
      if (wr_hi) begin
        cnt_nxt[15:8] = DAT_IN[7:0];
      end
    end else if (cmp_evt && spec) begin
      cnt_nxt = `TMB_CNT_ZERO;
    end else if (adv) begin
      cnt_nxt = 16'(cnt_r + `TMB_CNT_ONE);
    end
    // compare pair: write first, then capture
    cmp_nxt = cmp_r;
    if (wr_hit(wr_any, idx, `TMB_IDX_CMP_LO)) begin
      cmp_nxt[7:0] = DAT_IN[7:0];
    end else if (wr_hit(wr_any, idx, `TMB_IDX_CMP_HI)) begin
      cmp_nxt[15:8] = DAT_IN[7:0];
    end else if (cap_evt) begin
      cmp_nxt = cnt_r;
    end
    tctrl_nxt  = wr_hit(wr_any, idx, `TMB_IDX_TCTRL) ? DAT_IN[7:0] : tctrl_r;
    gate_nxt   = wr_hit(wr_any, idx, `TMB_IDX_GATE) ? DAT_IN[7:0] : gate_r;
    enable_nxt = wr_hit(wr_any, idx, `TMB_IDX_ENABLE) ? DAT_IN[7:0] : enable_r;
    irqc_nxt   = wr_hit(wr_any, idx, `TMB_IDX_IRQ_CTRL) ? DAT_IN[7:0] : irqc_r;
    ccu_nxt    = ccu_r;
    if (wr_hit(wr_any, idx, `TMB_IDX_CCU_CTRL)) begin
      ccu_nxt = tmb_ccu_type'(DAT_IN[3:0]);
    end
    // flags: software write, hardware set wins
    flag_nxt = flag_wr ? (DAT_IN[7:0] & `TMB_FLAG_MASK) : flag_r;
    if (ovf) begin
      flag_nxt[`TMB_BIT_OVF] = 1'b1;
    end
    if (cap_evt || cmp_evt) begin
      flag_nxt[`TMB_BIT_CCU] = 1'b1;
    end
    irq_nxt   = timer_on & enable_r[`TMB_BIT_OVF_IE] & irqc_r[`TMB_BIT_PERIPHERAL_IRQ_ENABLE]
              & global_irq_enable & flag_r[`TMB_BIT_OVF];
    match_nxt = match_now;
    ccpin_nxt = CCU_PIN_IN;
    cmpev_nxt = cmp_evt;
    ack_nxt   = CYC_IN & STB_IN & ~ack_r;
    dat_nxt   = rd_req ? {24'h0, rd_byte(idx)} : dat_r;
    // sleep and wake
    st_nxt  = st_r;
    vec_nxt = 1'b0;
    case (st_r)
      TMB_ST_AWAKE: begin
        if (SLEEP_IN) begin
          st_nxt = TMB_ST_ASLEEP;
        end
      end
      TMB_ST_ASLEEP: begin
        if (ovf && wake_ok) begin
          st_nxt  = TMB_ST_WAKE;
          vec_nxt = global_irq_enable;
        end else if (!SLEEP_IN) begin
          st_nxt = TMB_ST_AWAKE;
        end
      end
      TMB_ST_WAKE: begin
        st_nxt = TMB_ST_AWAKE;
      end
      default: begin
        st_nxt = TMB_ST_AWAKE;
      end
    endcase
  end
  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      cnt_r    <= `TMB_CNT_ZERO;
      cmp_r    <= `TMB_CNT_ZERO;
      tctrl_r  <= `TMB_RST_BYTE;
      gate_r   <= `TMB_RST_BYTE;
      ccu_r    <= TMB_CCU_OFF;
      flag_r   <= `TMB_RST_BYTE;
      enable_r <= `TMB_RST_BYTE;
      irqc_r   <= `TMB_RST_BYTE;
      ack_r    <= 1'b0;
      dat_r    <= 32'h0000_0000;
      st_r     <= TMB_ST_AWAKE;
      match_r  <= 1'b0;
      ccpin_r  <= 1'b0;
      cmpev_r  <= 1'b0;
      irq_r    <= 1'b0;
      vec_r    <= 1'b0;
    end else begin
      cnt_r    <= cnt_nxt;
      cmp_r    <= cmp_nxt;
      tctrl_r  <= tctrl_nxt;
      gate_r   <= gate_nxt;
      ccu_r    <= ccu_nxt;
      flag_r   <= flag_nxt;
      enable_r <= enable_nxt;
      irqc_r   <= irqc_nxt;
      ack_r    <= ack_nxt;
      dat_r    <= dat_nxt;
      st_r     <= st_nxt;
      match_r  <= match_nxt;
      ccpin_r  <= ccpin_nxt;
      cmpev_r  <= cmpev_nxt;
      irq_r    <= irq_nxt;
      vec_r    <= vec_nxt;
    end
  end
  // ****************************************
  // outputs
  // ****************************************
  assign DAT_OUT           = dat_r;
  assign ACK_OUT           = ack_r;
  assign COUNT_OUT         = cnt_r;
  assign COMPARE_EVENT_OUT = cmpev_r;
  assign IRQ_OUT           = irq_r;
  assign WAKE_OUT          = (st_r == TMB_ST_WAKE);
  assign VECTOR_REQ_OUT    = vec_r;
  assign ISR_VECTOR_OUT    = `TMB_ISR_VECTOR;
  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESETN_IN);
  sequence s_plain_step;
    adv && !cnt_wr && !(cmp_evt && spec);
  endsequence
  sequence s_sleep_ovf;
    (st_r == TMB_ST_ASLEEP) && ovf && wake_ok;
  endsequence
  property p_wrap;
    s_plain_step and (cnt_r == 16'hFFFF) |=> cnt_r == 16'h0000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("count did not wrap");
  property p_inc;
    s_plain_step and (cnt_r != 16'hFFFF) |=> cnt_r == 16'($past(cnt_r) + 16'h0001);
  endproperty
  a_inc: assert property (p_inc) else $error("count did not step by one");
  property p_flag_set;
    ovf |=> flag_r[0] ##1 (flag_r[0] || $past(flag_wr));
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("overflow flag not set");
  property p_irq;
    IRQ_OUT == $past(tctrl_r[0] && enable_r[0] && irqc_r[6] && irqc_r[7] && flag_r[0]);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt gating wrong");
  property p_flag_hold;
    flag_r[0] && !flag_wr |=> flag_r[0];
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag lost");
  property p_sleep_hold;
    SLEEP_IN && !async_mode && !cnt_wr && !(cmp_evt && spec) |=> $stable(cnt_r);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("count moved in sleep");
  property p_wake;
    s_sleep_ovf |=> WAKE_OUT ##1 !WAKE_OUT;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake pulse");
  property p_vector;
    s_sleep_ovf |=> VECTOR_REQ_OUT == $past(global_irq_enable) && ISR_VECTOR_OUT == 16'h0004;
  endproperty
  a_vector: assert property (p_vector) else $error("vector request wrong");
  property p_time_base;
    cap_evt && !wr_any |=> cmp_r == $past(COUNT_OUT);
  endproperty
  a_time_base: assert property (p_time_base) else $error("time base not used");
  property p_capture;
    cap_mode && CCU_PIN_IN && !ccpin_r && !wr_any |=> cmp_r == $past(cnt_r);
  endproperty
  a_capture: assert property (p_capture) else $error("capture missed");
  property p_compare;
    cmp_mode && (cnt_r == cmp_r) && !match_r |=> COMPARE_EVENT_OUT;
  endproperty
  a_compare: assert property (p_compare) else $error("compare event missed");
  property p_special;
    cmp_evt && spec && !cnt_wr && !flag_wr && !flag_r[0]
      |=> cnt_r == 16'h0000 && !flag_r[0];
  endproperty
  a_special: assert property (p_special) else $error("special clear wrong");
  property p_write_prio;
    wr_lo && !wr_hi && cmp_evt && spec |=> cnt_r[7:0] == $past(DAT_IN[7:0]);
  endproperty
  a_write_prio: assert property (p_write_prio) else $error("clear beat write");
endmodule

// [tb/tb.sv]
// self-checking bench of the sixteen-bit timer
// assumes tmb_consts.svh on the include path
`timescale 1ns/1ps
`include "tmb_consts.svh"
module tb;
  import tmb_pkg::*;
  logic clk, rstn, cyc, stb, we, ccu_pin, sleep_req, pin_run, sleep, pin, gate;
  logic [3:0]  sel, sel_v;
  logic [9:0]  adr;
  logic [31:0] dat_i, dat_o;
  logic ack, irq, wake, vreq, cev;
  logic [15:0] cnt, vec, hold;
  logic [7:0]  q;
  int err_total, samples_checked, cycles, n;
  tmb_timer #(.AW(10)) dut (.CLK_IN(clk), .RESETN_IN(rstn), .CYC_IN(cyc), .STB_IN(stb),
    .WE_IN(we), .ADR_IN(adr), .SEL_IN(sel), .DAT_IN(dat_i), .DAT_OUT(dat_o), .ACK_OUT(ack),
    .SLEEP_IN(sleep), .TIMER_PIN_IN(pin), .GATE_PIN_IN(gate), .CCU_PIN_IN(ccu_pin),
    .COUNT_OUT(cnt), .COMPARE_EVENT_OUT(cev), .IRQ_OUT(irq), .WAKE_OUT(wake),
    .VECTOR_REQ_OUT(vreq), .ISR_VECTOR_OUT(vec));
  tmb_core_model core (.clk_in(clk), .resetn_in(rstn), .sleep_req_in(sleep_req),
    .pin_run_in(pin_run), .wake_in(wake), .sleep_out(sleep), .pin_out(pin));
  // ****************************************
  // clock, timeout, shared tasks
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      complete_run();
    end
  end
  task automatic complete_run();
    if (err_total == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= sel_v;
    adr <= {idx, 2'b00};
    dat_i <= {24'h000000, d};
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wait_cnt(input logic [15:0] v, input int lim);
    n = 0;
    while (cnt !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic cycles_n(input int k);
    repeat (k) @(posedge clk);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset_and_carry();
    wb(0, `TMB_IDX_TCTRL, 0);
    chk(q, 0, "control reset");
    wb(0, 8'h40, 0);
    chk(q, 0, "unmapped read");
    wb(1, `TMB_IDX_CNT_LO, 8'hFF);
    wb(1, `TMB_IDX_CNT_HI, 8'h00);
    wb(1, `TMB_IDX_TCTRL, 8'h41);
    wait_cnt(16'h0100, 20);
    chk(cnt, 16'h0100, "carry");
    gate <= 1'b0;
    wb(1, `TMB_IDX_GATE, 8'h80);
    cycles_n(1);
    hold = cnt;
    cycles_n(5);
    chk(cnt, hold, "gated count");
    gate <= 1'b1;
    wb(1, `TMB_IDX_GATE, 8'h00);
    wb(1, `TMB_IDX_TCTRL, 8'h01);
    cycles_n(1);
    hold = cnt;
    cycles_n(8);
    chk(cnt, 16'(hold + 16'h0002), "instruction clock rate");
  endtask
  task automatic t_wrap_irq();
    wb(1, `TMB_IDX_TCTRL, 8'h40);
    wb(1, `TMB_IDX_CNT_LO, 8'hFD);
    wb(1, `TMB_IDX_CNT_HI, 8'hFF);
    wb(1, `TMB_IDX_FLAG, 8'h00);
    wb(1, `TMB_IDX_ENABLE, 8'h01);
    wb(1, `TMB_IDX_IRQ_CTRL, 8'hC0);
    wb(1, `TMB_IDX_TCTRL, 8'h41);
    wait_cnt(16'h0000, 30);
    chk(cnt, 16'h0000, "wrap");
    cycles_n(2);
    chk(irq, 1, "irq raised");
    cycles_n(20);
    wb(0, `TMB_IDX_FLAG, 0);
    chk(q & 8'h01, 1, "flag held");
    wb(1, `TMB_IDX_FLAG, 8'h00);
    cycles_n(2);
    chk(irq, 0, "irq after clear");
    wb(1, `TMB_IDX_IRQ_CTRL, 8'h40);
  endtask
  task automatic t_sleep();
    wb(1, `TMB_IDX_TCTRL, 8'h40);
    wb(1, `TMB_IDX_CNT_LO, 8'h00);
    wb(1, `TMB_IDX_CNT_HI, 8'h02);
    wb(1, `TMB_IDX_TCTRL, 8'h41);
    sleep_req <= 1'b1;
    wb(1, `TMB_IDX_CNT_HI, 8'h02);
    wb(1, `TMB_IDX_CNT_LO, 8'h00);
    cycles_n(10);
    chk(cnt, 16'h0200, "frozen asleep");
    sleep_req <= 1'b0;
    wb(1, `TMB_IDX_TCTRL, 8'h84);
    wb(1, `TMB_IDX_CNT_LO, 8'hFE);
    wb(1, `TMB_IDX_CNT_HI, 8'hFF);
    wb(1, `TMB_IDX_FLAG, 8'h00);
    wb(1, `TMB_IDX_IRQ_CTRL, 8'hC0);
    wb(1, `TMB_IDX_TCTRL, 8'h85);
    sleep_req <= 1'b1;
    pin_run <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wake !== 1'b1 && n < 100);
    chk(wake, 1, "wake");
    chk(vreq, 1, "vector request");
    chk(vec, `TMB_ISR_VECTOR, "vector");
    pin_run <= 1'b0;
    sleep_req <= 1'b0;
    wb(1, `TMB_IDX_IRQ_CTRL, 8'h00);
  endtask
  task automatic t_capture();
    wb(1, `TMB_IDX_TCTRL, 8'h40);
    wb(1, `TMB_IDX_CNT_LO, 8'h34);
    wb(1, `TMB_IDX_CNT_HI, 8'h12);
    wb(1, `TMB_IDX_CCU_CTRL, 8'h04);
    ccu_pin <= 1'b1;
    cycles_n(3);
    ccu_pin <= 1'b0;
    wb(0, `TMB_IDX_CMP_LO, 0);
    chk(q, 8'h34, "capture low");
    wb(0, `TMB_IDX_CMP_HI, 0);
    chk(q, 8'h12, "capture high");
    sel_v = 4'h0;
    wb(1, `TMB_IDX_CMP_LO, 8'hAA);
    sel_v = 4'h1;
    wb(0, `TMB_IDX_CMP_LO, 0);
    chk(q, 8'h34, "write without lane 0");
  endtask
  task automatic t_special();
    wb(1, `TMB_IDX_CNT_LO, 8'h00);
    wb(1, `TMB_IDX_CNT_HI, 8'h00);
    wb(1, `TMB_IDX_CMP_LO, 8'h10);
    wb(1, `TMB_IDX_CMP_HI, 8'h00);
    wb(1, `TMB_IDX_CCU_CTRL, 8'h0B);
    wb(1, `TMB_IDX_FLAG, 8'h00);
    wb(1, `TMB_IDX_TCTRL, 8'h41);
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (cev !== 1'b1 && n < 40);
      chk(cev, 1, "compare event");
    end
    cycles_n(3);
    chk({15'h0000, cnt < 16'h0010}, 1, "period clear");
    wb(0, `TMB_IDX_FLAG, 0);
    chk(q & 8'h01, 0, "no overflow flag");
    wait_cnt(16'h000D, 40);
    wb(1, `TMB_IDX_CNT_LO, 8'h55);
    cycles_n(1);
    chk(cev, 1, "write at match");
    chk(cnt, 16'h0055, "write beats clear");
  endtask
  task automatic t_mid_reset();
    rstn <= 1'b0;
    cycles_n(2);
    chk(cnt, 16'h0000, "count in reset");
    chk({15'h0000, irq | cev | wake | vreq}, 0, "outputs in reset");
    rstn <= 1'b1;
    wb(0, `TMB_IDX_CMP_LO, 0);
    chk(q, 0, "compare after reset");
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {cyc, stb, we, ccu_pin, sleep_req, pin_run} = '0;
    gate = 1'b1;
    sel = 4'h1;
    sel_v = 4'h1;
    adr = '0;
    dat_i = '0;
    err_total = 0;
    samples_checked = 0;
    cycles = 0;
    rstn = 1'b0;
    cycles_n(2);
    rstn <= 1'b1;
    t_reset_and_carry();
    t_wrap_irq();
    t_sleep();
    t_capture();
    t_special();
    t_mid_reset();
    complete_run();
  end
endmodule

// [tb/tmb_core_model.sv]
// core side of the timer: sleep level and external count pin
// assumes the bench asks for sleep and pin pulses on the clock edge
`timescale 1ns/1ps
module tmb_core_model (
  input  wire logic clk_in,
  input  wire logic resetn_in,
  input  wire logic sleep_req_in,
  input  wire logic pin_run_in,
  input  wire logic wake_in,
  output logic      sleep_out,
  output logic      pin_out
);
  logic woke_r;
  // ****************************************
  // sleep until the timer wakes the core
  // ****************************************
  assign sleep_out = sleep_req_in & ~woke_r;
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      woke_r  <= 1'b0;
      pin_out <= 1'b0;
    end else begin
      if (wake_in) woke_r <= 1'b1;
      else if (!sleep_req_in) woke_r <= 1'b0;
      pin_out <= pin_run_in & ~pin_out;
    end
  end
endmodule
